// ==== logic/rslv_pkg.sv ====
// Constants, field layout and types for the reset status and low supply
// detect block.
// Assumes a 50 MHz APB clock and one aligned 32-bit word per register.

package rslv_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 20;
  // Longest low width still rejected; a real reset request is longer.
  localparam int FILT_MIN_NS   = 200;
  // Least time rounds up to whole cycles.
  localparam int FILT_CYCLES   =
    (FILT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================================
  // Register byte offsets
  localparam logic [11:0] OFS_CAUSE    = 12'h000; // Read status, write wdt.
  localparam logic [11:0] OFS_IRQ_STAT = 12'h004;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h008;
  localparam logic [11:0] OFS_CTRL     = 12'h00C;

  // ==========================================================================
  // Reset cause register fields
  localparam int CB_LOW  = 0;  // Live low supply flag.
  localparam int CB_EXT  = 4;  // External pin reset.
  localparam int CB_WDT  = 5;  // Watchdog time-out.
  localparam int CB_STOP = 6;  // Recovery from stop mode.
  localparam int CB_POR  = 7;  // Power-on reset.
  localparam int CB_HI   = 4;  // First bit of the upper four.
  localparam logic [3:0] CAUSE_RST = 4'h8;

  // ==========================================================================
  // Interrupt status and mask fields
  localparam int IB_LOW  = 0;
  localparam int IB_EXT  = 1;
  localparam int IB_WDT  = 2;
  localparam int IRQ_W   = 3;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

  // ==========================================================================
  // Control register fields
  localparam int CT_BO_EN = 0;  // Brownout monitor enable.
  localparam logic CTRL_BO_RST = 1'b1;
  localparam int WDT_W = 8;
  localparam logic [WDT_W-1:0] WDT_RST = 8'h00;

  // Bus answer states.
  typedef enum logic {
    APB_IDLE,
    APB_ANSWER
  } rslv_apb_e;

endpackage

// ==== logic/rslv_rst_if.sv ====
// Carries the filtered external reset pin from the filter to the block.
// Assumes both ends share pclk.
`timescale 1ns/10ps
`default_nettype none

interface rslv_rst_if;
  logic pin_low;  // Synchronised pin level, high while the pin is low.
  logic evt;      // One-cycle pulse when a low pulse has qualified.
  modport src (output pin_low, output evt);
  modport snk (input  pin_low, input  evt);
endinterface

`default_nettype wire

// ==== logic/rslv_sync.sv ====
// Two-flop synchroniser for a group of asynchronous level inputs.
// Assumes the inputs are levels that stay put for several cycles.
`timescale 1ns/10ps
`default_nettype none

module rslv_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,     // Destination clock.
  input  wire logic         rst_n,   // Asynchronous reset, active low.
  input  wire logic [W-1:0] async_i, // Raw level inputs.
  output logic      [W-1:0] sync_o   // Synchronised levels.
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s1_d;
  logic [W-1:0] s2_d;

  if (W < 1) begin : g_chk
    $error("rslv_sync: W must be at least 1");
  end

  // Each bit walks through its own pair of flops.
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_comb begin
      s1_d[i] = async_i[i];
      s2_d[i] = s1_q[i];
    end
  end

  // Registers only; the first stage feeds the second and nothing else.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
    end
  end

  assign sync_o = s2_q;

endmodule

`default_nettype wire

// ==== logic/rslv_glitch_filter.sv ====
// Glitch filter for the external active-low reset pin.
// Assumes the pin is asynchronous to clk.
`timescale 1ns/10ps
`default_nettype none

module rslv_glitch_filter
  import rslv_pkg::*;
#(
  parameter int MIN_CYC = FILT_CYCLES
) (
  input  wire logic clk,     // System clock.
  input  wire logic rst_n,   // Asynchronous reset, active low.
  input  wire logic pin_n,   // Raw reset pin, active low.
  rslv_rst_if.src   rst_o    // Filtered pin and qualify pulse.
);

  localparam int CW = $clog2(MIN_CYC + 2);

  logic          s1_q;
  logic          s2_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          low;

  if (MIN_CYC < 1) begin : g_chk
    $error("rslv_glitch_filter: MIN_CYC must be at least 1");
  end

  // Count consecutive low cycles, saturating one past the minimum.
  always_comb begin
    low   = ~s2_q;
    cnt_d = cnt_q;
    if (!low) begin
      cnt_d = '0;
    end else if (cnt_q <= CW'(MIN_CYC)) begin
      cnt_d = cnt_q + CW'(1);
    end
  end

  // Synchroniser flops and the run counter; the pin idles high.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q  <= 1'b1;
      s2_q  <= 1'b1;
      cnt_q <= '0;
    end else begin
      s1_q  <= pin_n;
      s2_q  <= s1_q;
      cnt_q <= cnt_d;
    end
  end

  // A pulse no longer than the minimum never fires; a longer one fires once.
  assign rst_o.pin_low = low;
  assign rst_o.evt     = low && (cnt_q == CW'(MIN_CYC));

endmodule

`default_nettype wire

// ==== logic/rslv_top.sv ====
// Reset status and low supply detect block with an APB register slave.
// Assumes pclk at 50 MHz, presetn as power-on reset, and that the core
// drives stop_mode and wdt_timeout from pclk.
//
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/10ps
`default_nettype none

module rslv_top
  import rslv_pkg::*;
#(
  parameter int MIN_CYC = FILT_CYCLES
) (
  input  wire logic             pclk,            // System clock.
  input  wire logic             presetn,         // Power-on reset, low.
  input  wire logic [11:0]      paddr,           // APB byte address.
  input  wire logic             psel,            // APB select.
  input  wire logic             penable,         // APB enable.
  input  wire logic             pwrite,          // APB write.
  input  wire logic [31:0]      pwdata,          // APB write data.
  output logic      [31:0]      prdata,          // APB read data.
  output logic                  pready,          // APB ready.
  output logic                  pslverr,         // APB error.
  input  wire logic             ext_reset_pin_n, // Reset pin, low.
  input  wire logic             supply_low_pin,  // Supply comparator.
  input  wire logic             stop_mode,       // Core is in stop.
  input  wire logic             wdt_timeout,     // Watchdog pulse.
  output logic                  sys_reset_req,   // System reset pulse.
  output logic      [WDT_W-1:0] wdt_ctrl,        // Watchdog control.
  output logic                  wdt_ctrl_wr,     // Watchdog write pulse.
  output logic                  low_supply_flag, // Live low supply.
  output logic                  irq              // Interrupt, level.
);

  // ==========================================================================
  // Pin conditioning
  rslv_rst_if rif ();
  logic       sync_low;

  rslv_glitch_filter #(
    .MIN_CYC (MIN_CYC)
  ) u_filt (
    .clk   (pclk),
    .rst_n (presetn),
    .pin_n (ext_reset_pin_n),
    .rst_o (rif.src)
  );

  rslv_sync #(
    .W (1)
  ) u_sync (
    .clk     (pclk),
    .rst_n   (presetn),
    .async_i (supply_low_pin),
    .sync_o  (sync_low)
  );

  // ==========================================================================
  // State
  rslv_apb_e        apb_q,    apb_d;
  logic [31:0]      rdata_q,  rdata_d;
  logic             rdy_q,    rdy_d;
  logic             err_q,    err_d;
  logic [3:0]       cause_q,  cause_d;
  logic             low_q,    low_d;
  logic [IRQ_W-1:0] stat_q,   stat_d;
  logic [IRQ_W-1:0] mask_q,   mask_d;
  logic             bo_en_q,  bo_en_d;
  logic [WDT_W-1:0] wdt_q,    wdt_d;
  logic             wdt_wr_q, wdt_wr_d;
  logic             rst_q,    rst_d;
  logic             irq_q,    irq_d;
  logic             done;
  logic             wr_done;
  logic             rd_clr;
  logic [IRQ_W-1:0] evt;

  // Decoder used by the error answer only; the read mux decodes on its own.
  function automatic logic mapped(input logic [11:0] a);
    return (a == OFS_CAUSE) || (a == OFS_IRQ_STAT) ||
           (a == OFS_IRQ_MASK) || (a == OFS_CTRL);
  endfunction

  // Read view of every register; the cause view shows the live flag.
  function automatic logic [31:0] rd_view(input logic [11:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (1'b1)
      (a == OFS_CAUSE): begin
        v[CB_POR:CB_HI] = cause_q;
        v[CB_LOW]       = low_q;
      end
      (a == OFS_IRQ_STAT): v[IRQ_W-1:0] = stat_q;
      (a == OFS_IRQ_MASK): v[IRQ_W-1:0] = mask_q;
      (a == OFS_CTRL):     v[CT_BO_EN]  = bo_en_q;
      default:             v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // ==========================================================================
  // APB answer: one wait cycle, then ready with registered data.
  always_comb begin
    apb_d   = apb_q;
    rdy_d   = 1'b0;
    err_d   = 1'b0;
    rdata_d = rdata_q;
    unique case (apb_q)
      APB_IDLE: begin
        if (psel && penable) begin
          apb_d   = APB_ANSWER;
          rdy_d   = 1'b1;
          err_d   = !mapped(paddr);
          rdata_d = pwrite ? 32'h0000_0000 : rd_view(paddr);
        end
      end
      APB_ANSWER: begin
        apb_d = APB_IDLE;
      end
    endcase
  end

  assign done    = psel && penable && rdy_q;
  assign wr_done = done && pwrite;
  // Only a read of the status view clears the upper bits.
  assign rd_clr  = done && !pwrite && (paddr == OFS_CAUSE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_q   <= APB_IDLE;
      rdy_q   <= 1'b0;
      err_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      apb_q   <= apb_d;
      rdy_q   <= rdy_d;
      err_q   <= err_d;
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================================
  // Reset cause, low supply flag and reset request.
  always_comb begin
    cause_d = cause_q;
    // Brownout enable gates the detector; the flag just follows.
    low_d   = sync_low && bo_en_q;
    rst_d   = rif.evt;
    if (rif.evt) begin
      // Latest cause replaces the others; events beat a clearing read.
      cause_d = '0;
      cause_d[CB_EXT - CB_HI]  = 1'b1;
      cause_d[CB_STOP - CB_HI] = stop_mode;
    end else if (wdt_timeout) begin
      cause_d = '0;
      cause_d[CB_WDT - CB_HI]  = 1'b1;
      cause_d[CB_STOP - CB_HI] = stop_mode;
    end else if (rd_clr) begin
      cause_d = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause_q <= CAUSE_RST;
      low_q   <= 1'b0;
      rst_q   <= 1'b0;
    end else begin
      cause_q <= cause_d;
      low_q   <= low_d;
      rst_q   <= rst_d;
    end
  end

  // ==========================================================================
  // Writable registers: watchdog control shares the status address.
  always_comb begin
    mask_d   = mask_q;
    bo_en_d  = bo_en_q;
    wdt_d    = wdt_q;
    wdt_wr_d = 1'b0;
    if (wr_done) begin
      unique case (1'b1)
        (paddr == OFS_CAUSE): begin
          wdt_d    = pwdata[WDT_W-1:0];
          wdt_wr_d = 1'b1;
        end
        (paddr == OFS_IRQ_MASK): mask_d  = pwdata[IRQ_W-1:0];
        (paddr == OFS_CTRL):     bo_en_d = pwdata[CT_BO_EN];
        default: begin
          wdt_wr_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q   <= IRQ_RST;
      bo_en_q  <= CTRL_BO_RST;
      wdt_q    <= WDT_RST;
      wdt_wr_q <= 1'b0;
    end else begin
      mask_q   <= mask_d;
      bo_en_q  <= bo_en_d;
      wdt_q    <= wdt_d;
      wdt_wr_q <= wdt_wr_d;
    end
  end

  // ==========================================================================
  // Interrupts: sticky status, write one to clear, set wins.
  always_comb begin
    evt         = '0;
    evt[IB_LOW] = low_d && !low_q;
    evt[IB_EXT] = rif.evt;
    evt[IB_WDT] = wdt_timeout;
    stat_d      = stat_q;
    if (wr_done && (paddr == OFS_IRQ_STAT)) begin
      stat_d = stat_q & ~pwdata[IRQ_W-1:0];
    end
    stat_d = stat_d | evt;
    irq_d  = |(stat_d & mask_d);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= IRQ_RST;
      irq_q  <= 1'b0;
    end else begin
      stat_q <= stat_d;
      irq_q  <= irq_d;
    end
  end

  // Outputs straight from flops.
  assign prdata          = rdata_q;
  assign pready          = rdy_q;
  assign pslverr         = err_q;
  assign sys_reset_req   = rst_q;
  assign wdt_ctrl        = wdt_q;
  assign wdt_ctrl_wr     = wdt_wr_q;
  assign low_supply_flag = low_q;
  assign irq             = irq_q;

  // ==========================================================================
  // Checks
  localparam int RW = $clog2(MIN_CYC + 2);
  logic [RW-1:0] run_q;

  // Shadow count of low cycles seen by the filter.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= '0;
    end else if (!rif.pin_low) begin
      run_q <= '0;
    end else if (run_q <= RW'(MIN_CYC)) begin
      run_q <= run_q + RW'(1);
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_cause_read;
    psel && penable && !pwrite && rdy_q && (paddr == OFS_CAUSE);
  endsequence

  sequence s_cause_write;
    psel && penable && pwrite && rdy_q && (paddr == OFS_CAUSE);
  endsequence

  a_ext_reset_req: assert property (
    rif.evt && stop_mode |=> sys_reset_req && cause_q[CB_STOP - CB_HI])
    else $error("stop-mode pin reset did not request reset");

  a_glitch_width: assert property (
    rif.evt == (rif.pin_low && (run_q == RW'(MIN_CYC))))
    else $error("filter fired at the wrong low width");

  a_flag_sets: assert property (
    sync_low && bo_en_q |=> low_supply_flag)
    else $error("low supply flag not set");

  a_flag_tracks: assert property (
    !sync_low |=> !low_supply_flag)
    else $error("low supply flag latched");

  a_low_irq: assert property (
    $rose(low_supply_flag) && mask_q[IB_LOW] ##0
    !(wr_done && (paddr == OFS_IRQ_MASK || paddr == OFS_IRQ_STAT))
    |=> irq)
    else $error("low supply event gave no interrupt");

  a_bo_disable: assert property (
    !bo_en_q |=> !low_supply_flag)
    else $error("flag set with brownout monitor off");

  a_read_clear: assert property (
    s_cause_read ##0 !rif.evt && !wdt_timeout |=> cause_q == 4'h0)
    else $error("status read did not clear upper bits");

  a_shared_addr: assert property (
    s_cause_write |=> wdt_ctrl_wr && wdt_ctrl == $past(pwdata[WDT_W-1:0])
    ##1 !wdt_ctrl_wr)
    else $error("status address write missed watchdog control");

  a_cause_hold: assert property (
    !rif.evt && !wdt_timeout && !rd_clr |=> $stable(cause_q))
    else $error("cause bits changed without an event");

  a_read_only: assert property (
    s_cause_write ##0 !rif.evt && !wdt_timeout |=> $stable(cause_q))
    else $error("write changed the status register");

endmodule

`default_nettype wire

// ==== tb/rslv_far_model.sv ====
// Far-side model: the external reset pin driver and the supply comparator.
// Assumes the bench commands it on pclk and that the pin has a pull-up.
`timescale 1ns/10ps
`default_nettype none

module rslv_far_model (
  input  wire logic       pclk,            // System clock.
  input  wire logic       presetn,         // Power-on reset, low.
  input  wire logic       pulse_go,        // Start one low pulse.
  input  wire logic [7:0] pulse_len,       // Low width in cycles.
  input  wire logic       low_req,         // Ask for a low supply.
  output logic            ext_reset_pin_n, // Reset pin, low.
  output logic            supply_low_pin   // Comparator, high when low.
);
  // ==========================================================================
  // Pin driver
  logic [7:0] low_cnt_q;

  // Counts down the commanded low width; a short width is a glitch.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt_q <= 8'h00;
    end else if (pulse_go) begin
      low_cnt_q <= pulse_len;
    end else if (low_cnt_q != 8'h00) begin
      low_cnt_q <= low_cnt_q - 8'h01;
    end
  end

  // The pull-up holds the pin high whenever the driver lets go.
  assign ext_reset_pin_n = !presetn || (low_cnt_q == 8'h00);
  // The comparator follows the requested supply level at once.
  assign supply_low_pin  = low_req;
endmodule

`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the reset status and low supply block.
// Assumes rslv_top with a short filter and the far-side model beside it.
`timescale 1ns/10ps
`default_nettype none

module testbench
  import rslv_pkg::*;
;
  localparam int MINC = 2;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  wire         ext_reset_pin_n, supply_low_pin;
  logic        stop_mode, wdt_timeout, sys_reset_req, wdt_ctrl_wr, irq;
  logic        low_supply_flag, pulse_go, low_req;
  logic [WDT_W-1:0] wdt_ctrl;
  logic [7:0]  pulse_len;
  int          bad_count = 0;
  int          compares = 0;
  int          rst_pulses = 0;
  int          wr_pulses = 0;

  rslv_top #(.MIN_CYC(MINC)) rslv_top_i (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_reset_pin_n(ext_reset_pin_n),
    .supply_low_pin(supply_low_pin), .stop_mode(stop_mode),
    .wdt_timeout(wdt_timeout), .sys_reset_req(sys_reset_req),
    .wdt_ctrl(wdt_ctrl), .wdt_ctrl_wr(wdt_ctrl_wr),
    .low_supply_flag(low_supply_flag), .irq(irq));

  rslv_far_model rslv_far_model_i (
    .pclk(pclk), .presetn(presetn), .pulse_go(pulse_go),
    .pulse_len(pulse_len), .low_req(low_req),
    .ext_reset_pin_n(ext_reset_pin_n), .supply_low_pin(supply_low_pin));

  // ==========================================================================
  // Clock and pulse counters
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // Each one-cycle output pulse is counted once at the edge that sees it.
  always @(posedge pclk) begin
    if (sys_reset_req === 1'b1) rst_pulses++;
    if (wdt_ctrl_wr === 1'b1) wr_pulses++;
  end

  // ==========================================================================
  // Helpers
  // Prints the counts and the verdict, then stops the run.
  task automatic end_of_test();
    $display("compares %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // The answer stands for one cycle only.
    @(posedge pclk);
    chk("pready pulse", 32'h0000_0000, 32'(pready));
  endtask

  // Reads a register and compares data and error.
  task automatic rd(input logic [11:0] a, input logic [31:0] exp,
                    input logic err);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk($sformatf("read %h", a), exp, r);
    chk($sformatf("error %h", a), 32'(err), 32'(e));
  endtask

  // Writes a register and compares the error.
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic err);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
    chk($sformatf("error %h", a), 32'(err), 32'(e));
  endtask

  // Waits whole cycles, then steps past the edge updates.
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  // Asks the far side for one low pulse of n cycles.
  task automatic pulse(input logic [7:0] n);
    @(posedge pclk);
    pulse_go  <= 1'b1;
    pulse_len <= n;
    @(posedge pclk);
    pulse_go  <= 1'b0;
  endtask

  // ==========================================================================
  // Tests
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0000_0000; stop_mode = 1'b0;
    wdt_timeout = 1'b0; pulse_go = 1'b0; pulse_len = 8'h00;
    low_req = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_CAUSE, 32'(CAUSE_RST) << CB_HI, 1'b0);
    rd(OFS_CAUSE, 32'h0000_0000, 1'b0);
    rd(OFS_IRQ_MASK, 32'h0000_0000, 1'b0);
    rd(OFS_CTRL, 32'(CTRL_BO_RST), 1'b0);
    wr(12'h010, 32'hFFFF_FFFF, 1'b1);
    rd(12'h010, 32'h0000_0000, 1'b1);
    $display("test reset values done");
    wr(OFS_CAUSE, 32'h0000_005A, 1'b0);
    cyc(2);
    chk("wdt_ctrl", 32'h0000_005A, 32'(wdt_ctrl));
    chk("wdt writes", 32'h0000_0001, 32'(wr_pulses));
    rd(OFS_CAUSE, 32'h0000_0000, 1'b0);
    $display("test shared address done");
    @(posedge pclk);
    stop_mode <= 1'b1;
    pulse(8'(MINC));
    cyc(12);
    chk("reset pulses", 32'h0000_0000, 32'(rst_pulses));
    rd(OFS_IRQ_STAT, 32'h0000_0000, 1'b0);
    pulse(8'(MINC + 4));
    cyc(14);
    chk("reset pulses", 32'h0000_0001, 32'(rst_pulses));
    @(posedge pclk);
    stop_mode <= 1'b0;
    rd(OFS_CAUSE, (32'h1 << CB_EXT) | (32'h1 << CB_STOP), 1'b0);
    rd(OFS_IRQ_STAT, 32'h1 << IB_EXT, 1'b0);
    chk("masked irq", 32'h0000_0000, 32'(irq));
    wr(OFS_IRQ_STAT, 32'h0000_0007, 1'b0);
    $display("test stop recovery done");
    @(posedge pclk);
    wdt_timeout <= 1'b1;
    @(posedge pclk);
    wdt_timeout <= 1'b0;
    cyc(2);
    rd(OFS_CAUSE, 32'h1 << CB_WDT, 1'b0);
    rd(OFS_IRQ_STAT, 32'h1 << IB_WDT, 1'b0);
    wr(OFS_IRQ_STAT, 32'h0000_0007, 1'b0);
    $display("test watchdog done");
    wr(OFS_IRQ_MASK, 32'h1 << IB_LOW, 1'b0);
    low_req <= 1'b1;
    cyc(6);
    chk("low flag", 32'h0000_0001, 32'(low_supply_flag));
    chk("irq", 32'h0000_0001, 32'(irq));
    rd(OFS_CAUSE, 32'h1 << CB_LOW, 1'b0);
    wr(OFS_CAUSE, 32'h0000_0000, 1'b0);
    rd(OFS_CAUSE, 32'h1 << CB_LOW, 1'b0);
    low_req <= 1'b0;
    cyc(6);
    chk("low flag", 32'h0000_0000, 32'(low_supply_flag));
    chk("irq held", 32'h0000_0001, 32'(irq));
    wr(OFS_IRQ_STAT, 32'h1 << IB_LOW, 1'b0);
    cyc(2);
    chk("irq cleared", 32'h0000_0000, 32'(irq));
    $display("test low supply done");
    wr(OFS_CTRL, 32'h0000_0000, 1'b0);
    low_req <= 1'b1;
    cyc(6);
    chk("low flag", 32'h0000_0000, 32'(low_supply_flag));
    rd(OFS_IRQ_STAT, 32'h0000_0000, 1'b0);
    low_req <= 1'b0;
    wr(OFS_CTRL, 32'h0000_0001, 1'b0);
    $display("test brownout off done");
    end_of_test();
  end

  // Cuts a hang short well after the tests should have ended.
  initial begin
    #200000;
    bad_count++;
    $display("watchdog expired");
    end_of_test();
  end
endmodule

`default_nettype wire
